// file: hw/sbi_pkg.sv
/*
 Register map, field positions, reset values and timer constants for the
 single-bit serial bus interface with its bus timer.
 Assumes one machine cycle of the bus timer per sys_clk rising edge.
*/
// Operation
// (R1) One bit per handshake, checks, stretching, timeout
// (R2) Low timer bits enforce four minimum spans
// (R3) Timer on CPU clock, four prescale preloads
// (R4) Full ten-bit timer, cleared by SCL edges
// (R5) Frame runs from start to stop
// (R6) Timer halted between frames
// (R7) Carry out after 1020-1023 quiet cycles
// (R8) Carry resets interface, releases SCL, interrupts
// (R9) Timer runs only with run bit set
// (R10) Timer interrupt enable bit 7, settable priority
// (R11) Bus interrupt enable bit 0, settable priority
// (R12) Attention with enables requests bus interrupt
// (R13) Software enables bus interrupt only sparingly
// (R14) SDA sampled into received bit at SCL rise
// (R15) Received bit in data register, zeros below
// (R16) Data read clears ready; status read not
// (R17) Attention is OR of four flags
// (R18) Ready set each SCL rise, except idle slave
// (R19) Ready cleared by clear bit or data access
// (R20) SCL held low until ready cleared
// (R21) Timer extends fast-response SCL low phase
// (R22) SDA driven low only when transmitting, SCL low; code also pulls it low with SCL high to generate a start
// (R23) SCL edge preloads eight minus span count
// (R24) Start flag not set when activating idle slave
// (R25) Writing one clears only its own flag
package sbi_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_DATA = 3'h1;
    localparam logic [2:0] ADDR_CFG = 3'h2;
    localparam logic [2:0] ADDR_IEN2 = 3'h3;
    localparam logic [2:0] ADDR_IRQ_ENABLE_SECOND = 3'h4;
    localparam logic [2:0] ADDR_PRIO = 3'h5;
    // Control write bits / status read bits
    localparam int CB_CLR_XMIT = 7;
    localparam int CB_IDLE = 6;
    localparam int CB_CLR_READY = 5;
    localparam int CB_CLR_ARL = 4;
    localparam int CB_CLR_START = 3;
    localparam int CB_CLR_STOP = 2;
    localparam int CB_XMIT_START = 1;
    localparam int CB_XMIT_STOP = 0;
    localparam int SB_RXBIT = 7;
    localparam int SB_ATTN = 6;
    localparam int SB_READY = 5;
    localparam int SB_ARL = 4;
    localparam int SB_START = 3;
    localparam int SB_STOP = 2;
    localparam int SB_MASTER = 1;
    // Configuration, interrupt enable and data register bits
    localparam int FB_PRESCALE_LOW = 0;
    localparam int FB_PRESCALE_HIGH = 1;
    localparam int FB_TIMER_RUN = 4;
    localparam int FB_MASTER_REQ = 5;
    localparam int FB_SLAVE_EN = 6;
    localparam int IB_TIMER = 7;
    localparam int IB_SERIAL = 0;
    localparam int IB_GLOBAL = 7;
    localparam int DATA_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Minimum span in machine cycles per prescale setting
    localparam logic [9:0] SPAN_CNT0 = 10'h005;
    localparam logic [9:0] SPAN_CNT1 = 10'h006;
    localparam logic [9:0] SPAN_CNT2 = 10'h007;
    localparam logic [9:0] SPAN_CNT3 = 10'h008;
    localparam logic [9:0] SPAN_DONE = 10'h008;
    localparam logic [9:0] TIMER_LAST = 10'h3ff;
endpackage

// file: hw/sbi_top.sv
/*
 Single-bit serial bus interface with bus timer: register port, SCL/SDA
 open-drain control, flags, stretching, and timeout reset.
 Assumes pin inputs synchronous to sys_clk and a 25 MHz clock.
*/
`timescale 1ns/1ns
module sbi_top (
    input wire logic sys_clk, // 25 MHz clock
    input wire logic reset_n, // Asynchronous reset
    input wire logic [sbi_pkg::ADDR_W-1:0] reg_addr, // Register index
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic scl_in, // SCL level
    output logic scl_oe, // Pull SCL low
    input wire logic sda_in, // SDA level
    output logic sda_oe, // Pull SDA low
    output logic serial_bus_irq, // Attention interrupt request
    output logic bus_timer_irq // Timeout interrupt pulse
);
    import sbi_pkg::*;

    logic scl_prev_reg, sda_prev_reg;
    logic rx_bit_reg, ready_reg, arl_reg, start_reg, stop_reg;
    logic master_reg, idle_reg, frame_reg, xmit_reg, xmit_bit_reg, sda_drive_reg;
    logic pend_start_reg, pend_stop_reg;
    logic [7:0] cfg_reg, ien2_reg, irq_enable_second_reg, prio_reg, rdata_reg;
    logic [9:0] timer_reg, timer_next;
    logic scl_oe_reg, sda_oe_reg, sirq_reg, tirq_reg;

    wire wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
    wire wr_data = reg_wr && reg_addr == ADDR_DATA;
    wire rd_data = reg_rd && reg_addr == ADDR_DATA;
    wire scl_rise = scl_in && !scl_prev_reg;
    wire scl_fall = !scl_in && scl_prev_reg;
    wire scl_edge = scl_rise || scl_fall;
    wire start_cond = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
    wire stop_cond = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;
    wire slave_idle = idle_reg && !master_reg;
    // (R17) attention is the OR of the flags
    wire attention = ready_reg || arl_reg || start_reg || stop_reg;
    wire timer_run = cfg_reg[FB_TIMER_RUN];
    wire [1:0] prescale = {cfg_reg[FB_PRESCALE_HIGH], cfg_reg[FB_PRESCALE_LOW]};
    // (R3) four preload choices from the prescale field
    wire [9:0] span_cnt = prescale == 2'h0 ? SPAN_CNT0 : prescale == 2'h1 ? SPAN_CNT1 :
                          prescale == 2'h2 ? SPAN_CNT2 : SPAN_CNT3;
    // (R23) preload eight minus the span count
    wire [9:0] preload = SPAN_DONE - span_cnt;
    // (R2) low bits reaching eight mark the minimum span
    wire span_met = timer_reg >= SPAN_DONE;
    // (R7) carry out at the top of the ten-bit count
    wire carry = timer_run && frame_reg && timer_reg == TIMER_LAST;
    wire wr_xstart = wr_ctrl && reg_wdata[CB_XMIT_START];
    wire wr_xstop = wr_ctrl && reg_wdata[CB_XMIT_STOP];
    // (R22) ARBITRATION_LOST_FLAG: SDA seen low at SCL rise while transmitting a zero bit
    wire arl_set = xmit_reg && !sda_drive_reg && scl_rise && !sda_in;
    wire ready_set = scl_rise && !slave_idle;
    // (R16) data access or clear bit ends ready
    wire ready_clr = (wr_ctrl && reg_wdata[CB_CLR_READY]) || wr_data || rd_data;
    // (R24) no start flag for an idle slave
    wire start_set = start_cond && !slave_idle;
    wire stop_set = stop_cond && !slave_idle;
    wire master_set = cfg_reg[FB_MASTER_REQ] && !frame_reg && !master_reg;
    wire gen_start = master_reg && !frame_reg && scl_in && span_met && !sda_oe_reg;
    // Master drives SCL: low after high span, high after low span when no flags
    wire mst_scl_low = master_reg && frame_reg && scl_in && span_met
                       && !pend_start_reg && !pend_stop_reg;
    wire mst_scl_hold = master_reg && !scl_in && !span_met;
    // (R20) stretch the low phase while a flag is pending
    wire stretch = !scl_in && attention && !slave_idle;
    wire master_or_busy = master_reg || frame_reg;
    wire scl_oe_next = (stretch || mst_scl_low || mst_scl_hold ||
                        (scl_oe_reg && !scl_in && (attention || !span_met)))
                       && master_or_busy;

    always_comb begin
        timer_next = timer_reg;
        // (R9) run bit gates the timer; (R4) SCL edges reload it
        if (!timer_run) begin
            timer_next = SPAN_DONE;
        end else if (scl_edge || start_cond || stop_cond) begin
            timer_next = preload;
        end else if (frame_reg) begin
            timer_next = 10'(timer_reg + 10'h001);
        end else if (!span_met) begin
            // (R6) between frames only finish the span, then halt
            timer_next = 10'(timer_reg + 10'h001);
        end
    end

    wire [7:0] status_rd = {rx_bit_reg, attention, ready_reg, arl_reg, start_reg,
                            stop_reg, master_reg, 1'b0};
    // (R15) received bit over seven zero bits
    wire [7:0] data_rd = {rx_bit_reg, 7'h00};
    wire [7:0] rd_mux = reg_addr == ADDR_CTRL ? status_rd :
                        reg_addr == ADDR_DATA ? data_rd :
                        reg_addr == ADDR_CFG ? cfg_reg :
                        reg_addr == ADDR_IEN2 ? ien2_reg :
                        reg_addr == ADDR_IRQ_ENABLE_SECOND ? irq_enable_second_reg :
                        reg_addr == ADDR_PRIO ? prio_reg : 8'h00;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg <= CFG_RESET;
            ien2_reg <= 8'h00;
            irq_enable_second_reg <= 8'h00;
            prio_reg <= 8'h00;
            rdata_reg <= 8'h00;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            timer_reg <= SPAN_DONE;
        end else begin
            if (reg_wr && reg_addr == ADDR_CFG) cfg_reg <= reg_wdata;
            // (R10) (R11) enable bits and priority stored here
            if (reg_wr && reg_addr == ADDR_IEN2) ien2_reg <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_IRQ_ENABLE_SECOND) irq_enable_second_reg <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_PRIO) prio_reg <= reg_wdata;
            rdata_reg <= reg_rd ? rd_mux : 8'h00;
            scl_prev_reg <= scl_in;
            sda_prev_reg <= sda_in;
            timer_reg <= timer_next;
        end
    end

    // (R1) bit handshake state; a timer carry returns it to reset values except rx_bit_reg, xmit_bit_reg and sda_drive_reg
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_bit_reg <= 1'b0;
            ready_reg <= 1'b0;
            arl_reg <= 1'b0;
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
            master_reg <= 1'b0;
            idle_reg <= 1'b1;
            frame_reg <= 1'b0;
            xmit_reg <= 1'b0;
            xmit_bit_reg <= 1'b1;
            sda_drive_reg <= 1'b1;
            pend_start_reg <= 1'b0;
            pend_stop_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (carry) begin
            // (R8) timeout resets the interface and releases SCL
            ready_reg <= 1'b0;
            arl_reg <= 1'b0;
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
            master_reg <= 1'b0;
            idle_reg <= 1'b1;
            frame_reg <= 1'b0;
            xmit_reg <= 1'b0;
            pend_start_reg <= 1'b0;
            pend_stop_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            // (R14) sample SDA at each SCL rise
            if (scl_rise) rx_bit_reg <= sda_in;
            // (R18) (R19) (R25) set wins over clear
            ready_reg <= ready_set || (ready_reg && !ready_clr);
            arl_reg <= arl_set || (arl_reg && !(wr_ctrl && reg_wdata[CB_CLR_ARL]));
            start_reg <= start_set || (start_reg && !(wr_ctrl && reg_wdata[CB_CLR_START]));
            stop_reg <= stop_set || (stop_reg && !(wr_ctrl && reg_wdata[CB_CLR_STOP]));
            // (R5) frame from start to stop
            if (start_cond) begin
                frame_reg <= 1'b1;
                idle_reg <= 1'b0;
            end else if (stop_cond) begin
                frame_reg <= 1'b0;
            end
            if (wr_ctrl && reg_wdata[CB_IDLE]) idle_reg <= 1'b1;
            if (arl_set || (stop_cond && !cfg_reg[FB_MASTER_REQ])) begin
                master_reg <= 1'b0;
            end else if (master_set) begin
                master_reg <= 1'b1;
            end
            // Transmit active and the bit to send
            if (arl_set || rd_data || (wr_ctrl && reg_wdata[CB_CLR_XMIT])) begin
                xmit_reg <= 1'b0;
            end else if (wr_data || wr_xstart || wr_xstop) begin
                xmit_reg <= 1'b1;
            end
            if (wr_xstart) begin
                xmit_bit_reg <= 1'b1;
            end else if (wr_xstop) begin
                xmit_bit_reg <= 1'b0;
            end else if (wr_data) begin
                xmit_bit_reg <= reg_wdata[DATA_BIT];
            end
            if (wr_xstart) pend_start_reg <= 1'b1;
            if (wr_xstop) pend_stop_reg <= 1'b1;
            // (R22) transmit bit reaches SDA only while SCL is low
            if (!scl_in) sda_drive_reg <= xmit_bit_reg;
            // (R21) SCL edges wait for the span to elapse
            scl_oe_reg <= scl_oe_next;
            if (!xmit_reg && !gen_start) begin
                sda_oe_reg <= 1'b0;
            end else if (gen_start) begin
                sda_oe_reg <= 1'b1;
            end else if (!scl_in) begin
                sda_oe_reg <= !sda_drive_reg;
            end else if (pend_start_reg && span_met) begin
                sda_oe_reg <= 1'b1;
                pend_start_reg <= 1'b0;
            end else if (pend_stop_reg && span_met) begin
                sda_oe_reg <= 1'b0;
                pend_stop_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sirq_reg <= 1'b0;
            tirq_reg <= 1'b0;
        end else begin
            // (R12) attention with both enables
            sirq_reg <= attention && irq_enable_second_reg[IB_GLOBAL] && ien2_reg[IB_SERIAL];
            // (R8) (R10) timeout interrupt when enabled
            tirq_reg <= carry && irq_enable_second_reg[IB_GLOBAL] && ien2_reg[IB_TIMER];
        end
    end

    assign reg_rdata = rdata_reg;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;
    assign serial_bus_irq = sirq_reg;
    assign bus_timer_irq = tirq_reg;

    property p_rise_samples;
        @(posedge sys_clk) disable iff (!reset_n)
        scl_rise && !carry |=> rx_bit_reg == $past(sda_in);
    endproperty
    a_rise_samples: assert property (p_rise_samples) else $error("rx bit not sampled"); // R14
    property p_ready_set;
        @(posedge sys_clk) disable iff (!reset_n)
        scl_rise && !slave_idle && !carry |=> ready_reg;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set"); // R18
    property p_data_read_clears;
        @(posedge sys_clk) disable iff (!reset_n)
        rd_data && !scl_rise |=> !ready_reg;
    endproperty
    a_data_read_clears: assert property (p_data_read_clears) else $error("ready kept"); // R16
    property p_attention_or;
        @(posedge sys_clk) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_CTRL |=>
            reg_rdata[SB_ATTN] == (reg_rdata[SB_READY] || reg_rdata[SB_ARL] ||
                                   reg_rdata[SB_START] || reg_rdata[SB_STOP]);
    endproperty
    a_attention_or: assert property (p_attention_or) else $error("attention wrong"); // R17
    property p_data_zeros;
        @(posedge sys_clk) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_DATA |=> reg_rdata[6:0] == 7'h00;
    endproperty
    a_data_zeros: assert property (p_data_zeros) else $error("data low bits set"); // R15
    property p_carry_resets;
        @(posedge sys_clk) disable iff (!reset_n)
        carry |=> !scl_oe && !frame_reg && !ready_reg;
    endproperty
    a_carry_resets: assert property (p_carry_resets) else $error("no timeout reset"); // R8
    property p_timer_halt;
        @(posedge sys_clk) disable iff (!reset_n)
        !frame_reg && span_met && !scl_edge && !start_cond && !stop_cond
            |=> $stable(timer_reg);
    endproperty
    a_timer_halt: assert property (p_timer_halt) else $error("timer ran idle"); // R6
    property p_edge_preload;
        @(posedge sys_clk) disable iff (!reset_n)
        timer_run && scl_fall |=> timer_reg == $past(preload);
    endproperty
    a_edge_preload: assert property (p_edge_preload) else $error("no preload"); // R23
    property p_stretch;
        @(posedge sys_clk) disable iff (!reset_n)
        stretch && frame_reg && !carry |=> scl_oe;
    endproperty
    a_stretch: assert property (p_stretch) else $error("scl not stretched"); // R20
    property p_sda_needs_xmit;
        @(posedge sys_clk) disable iff (!reset_n)
        sda_oe && !frame_reg |-> master_reg || xmit_reg || $past(xmit_reg);
    endproperty
    a_sda_needs_xmit: assert property (p_sda_needs_xmit) else $error("sda driven"); // R22
    c_timeout: cover property (@(posedge sys_clk) carry);
    c_ready: cover property (@(posedge sys_clk) ready_set ##[1:20] ready_clr);
    c_frame: cover property (@(posedge sys_clk) start_cond ##[1:200] stop_cond);
    c_stretch: cover property (@(posedge sys_clk) stretch && frame_reg);
    c_stop_flag: cover property (@(posedge sys_clk) stop_set);

    property p_stat_keep;
        @(posedge sys_clk) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_CTRL && ready_reg && !carry |=> ready_reg;
    endproperty
    a_stat_keep: assert property (p_stat_keep) else $error("status read cleared ready"); // R16

    property p_clr_ready;
        @(posedge sys_clk) disable iff (!reset_n)
        wr_ctrl && reg_wdata[CB_CLR_READY] && !scl_rise |=> !ready_reg;
    endproperty
    a_clr_ready: assert property (p_clr_ready) else $error("clear bit kept ready"); // R19

    property p_keep_start;
        @(posedge sys_clk) disable iff (!reset_n)
        wr_ctrl && !reg_wdata[CB_CLR_START] && start_reg && !carry |=> start_reg;
    endproperty
    a_keep_start: assert property (p_keep_start) else $error("start flag lost"); // R25

    property p_keep_stop;
        @(posedge sys_clk) disable iff (!reset_n)
        wr_ctrl && !reg_wdata[CB_CLR_STOP] && stop_reg && !carry |=> stop_reg;
    endproperty
    a_keep_stop: assert property (p_keep_stop) else $error("stop flag lost"); // R25

    property p_idle_start;
        @(posedge sys_clk) disable iff (!reset_n)
        start_cond && slave_idle && !start_reg |=> !start_reg;
    endproperty
    a_idle_start: assert property (p_idle_start) else $error("idle slave start flag"); // R24

    property p_idle_ready;
        @(posedge sys_clk) disable iff (!reset_n)
        scl_rise && slave_idle && !ready_reg |=> !ready_reg;
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("idle slave ready"); // R18

    property p_irq_req;
        @(posedge sys_clk) disable iff (!reset_n)
        attention && irq_enable_second_reg[IB_GLOBAL] && ien2_reg[IB_SERIAL] |=> serial_bus_irq;
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("no bus interrupt"); // R12

    property p_tirq_req;
        @(posedge sys_clk) disable iff (!reset_n)
        carry && irq_enable_second_reg[IB_GLOBAL] && ien2_reg[IB_TIMER] |=> bus_timer_irq;
    endproperty
    a_tirq_req: assert property (p_tirq_req) else $error("no timer interrupt"); // R10

    property p_run_gate;
        @(posedge sys_clk) disable iff (!reset_n)
        !timer_run |=> !bus_timer_irq;
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("timer fired while stopped"); // R9

    property p_frame_on;
        @(posedge sys_clk) disable iff (!reset_n)
        start_cond && !carry |=> frame_reg;
    endproperty
    a_frame_on: assert property (p_frame_on) else $error("frame not opened"); // R5

    property p_frame_off;
        @(posedge sys_clk) disable iff (!reset_n)
        stop_cond && !carry |=> !frame_reg;
    endproperty
    a_frame_off: assert property (p_frame_off) else $error("frame not closed"); // R5

    property p_arl_xmit;
        @(posedge sys_clk) disable iff (!reset_n)
        arl_set && !carry |=> arl_reg && !xmit_reg;
    endproperty
    a_arl_xmit: assert property (p_arl_xmit) else $error("arbitration loss missed"); // R1

    property p_rise_load;
        @(posedge sys_clk) disable iff (!reset_n)
        timer_run && scl_rise |=> timer_reg == $past(preload);
    endproperty
    a_rise_load: assert property (p_rise_load) else $error("no preload at rise"); // R4

    property p_low_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        scl_oe && !scl_in && !span_met && frame_reg && !carry |=> scl_oe;
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("low span cut short"); // R21

    property p_release;
        @(posedge sys_clk) disable iff (!reset_n)
        !scl_in && !attention && span_met && !master_reg && !carry |=> !scl_oe;
    endproperty
    a_release: assert property (p_release) else $error("scl not released"); // R20
endmodule

// file: tb/sbi_bus_master.sv
/*
 Behavioural far-side bus master that drives SCL and SDA open-drain.
 Assumes the bench resolves both wires with pull-ups and feeds SCL back.
*/
`timescale 1ns/1ns
module sbi_bus_master (
    input wire logic sys_clk, // Bench clock
    input wire logic scl, // Resolved SCL wire
    output logic scl_low, // Pull SCL low
    output logic sda_low // Pull SDA low
);
    int hang = 0;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Lets go of SCL and waits while the device stretches it
    task automatic release_scl();
        int i;
        scl_low <= 1'b0;
        for (i = 0; i < 3000 && scl !== 1'b1; i++) @(posedge sys_clk);
        if (scl !== 1'b1) hang++;
        wait_n(10);
    endtask
    task automatic start();
        sda_low <= 1'b0;
        wait_n(10);
        release_scl();
        sda_low <= 1'b1;
        wait_n(10);
        scl_low <= 1'b1;
        wait_n(10);
    endtask
    // Data changes only while SCL is low
    task automatic bit_rise(input logic b);
        sda_low <= ~b;
        wait_n(10);
        release_scl();
    endtask
    task automatic bit_fall();
        scl_low <= 1'b1;
        wait_n(10);
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        wait_n(10);
        release_scl();
        sda_low <= 1'b0;
        wait_n(10);
    endtask
endmodule

// file: tb/tb_top.sv
/*
 Self-checking bench for the single-bit serial bus interface.
 Assumes the far side is the behavioural master and pull-ups on both wires.
*/
`timescale 1ns/1ns
module tb_top;
    import sbi_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic scl_oe, sda_oe, serial_bus_irq, bus_timer_irq;
    logic m_scl_low, m_sda_low, scl_w, sda_w;
    int errors = 0;
    int n_checks = 0;
    int seed = 32'h480e;
    int e_rx = 0, e_ready = 0, e_start = 0, e_stop = 0;
    int i, k, n;
    logic [7:0] d, v;
    logic b, seen;
    assign scl_w = ~(scl_oe | m_scl_low);
    assign sda_w = ~(sda_oe | m_sda_low);
    always #20 sys_clk = ~sys_clk;
    sbi_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_in(scl_w), .scl_oe(scl_oe), .sda_in(sda_w), .sda_oe(sda_oe),
        .serial_bus_irq(serial_bus_irq), .bus_timer_irq(bus_timer_irq));
    sbi_bus_master m (.sys_clk(sys_clk), .scl(scl_w), .scl_low(m_scl_low),
        .sda_low(m_sda_low));
    task automatic results();
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %0t: read %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %0t: signal %b expected %b", $time, g, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] w);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] r);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        r = reg_rdata;
    endtask
    function automatic logic [7:0] exp_status();
        logic a;
        a = (e_ready + e_start + e_stop) != 0;
        return {e_rx[0], a, e_ready[0], 1'b0, e_start[0], e_stop[0], 2'b00};
    endfunction
    task automatic check_status();
        logic [7:0] r;
        rd(ADDR_CTRL, r);
        chk8(r, exp_status());
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(i[2:0], d);
            chk8(d, 8'h00);
        end
        v = 8'($random(seed));
        wr(ADDR_PRIO, v);
        rd(ADDR_PRIO, d);
        chk8(d, v);
        wr(3'h6, v);
        rd(3'h6, d);
        chk8(d, 8'h00);
        for (i = 3; i >= 0; i--) begin
            wr(ADDR_CFG, 8'h40 | i[7:0]);
            rd(ADDR_CFG, d);
            chk8(d, 8'h40 | i[7:0]);
        end
        wr(ADDR_IEN2, 8'h81);
        rd(ADDR_IEN2, d);
        chk8(d, 8'h81);
        wr(ADDR_IRQ_ENABLE_SECOND, 8'h80);
        m.bit_fall();
        chk1(scl_oe, 1'b0);
        m.bit_rise(1'b1);
        e_rx = 1;
        check_status();
        m.start();
        check_status();
        for (k = 0; k < 2; k++) begin
            b = 1'($random(seed));
            m.bit_rise(b);
            e_rx = b;
            e_ready = 1;
            check_status();
            check_status();
            chk1(serial_bus_irq, 1'b1);
            m.bit_fall();
            chk1(scl_oe, 1'b1);
            if (k == 0) begin
                seen = 1'b0;
                for (i = 0; i < 1100; i++) begin
                    @(posedge sys_clk);
                    #1;
                    seen = seen | (bus_timer_irq === 1'b1);
                end
                chk1(seen, 1'b0);
                chk1(scl_oe, 1'b1);
                rd(ADDR_DATA, d);
                chk8(d, {b, 7'h00});
                e_ready = 0;
            end else begin
                wr(ADDR_CTRL, 8'h00);
                check_status();
                wr(ADDR_CTRL, 8'h08);
                check_status();
                wr(ADDR_CTRL, 8'h20);
                e_ready = 0;
            end
            check_status();
            for (i = 0; i < 20 && scl_oe !== 1'b0; i++) begin
                @(posedge sys_clk);
                #1;
            end
            chk1(scl_oe, 1'b0);
            chk1(serial_bus_irq, 1'b0);
        end
        m.stop();
        e_rx = 0;
        e_ready = 1;
        e_stop = 1;
        check_status();
        wr(ADDR_CTRL, 8'h24);
        e_ready = 0;
        e_stop = 0;
        check_status();
        wr(ADDR_CFG, 8'h50);
        m.start();
        wr(ADDR_CTRL, 8'h08);
        m.bit_rise(1'b1);
        m.bit_fall();
        for (n = 10; n < 1100 && bus_timer_irq !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        chk1(n >= 1020 && n <= 1026, 1'b1);
        @(posedge sys_clk);
        #1;
        chk1(scl_oe, 1'b0);
        rd(ADDR_CTRL, d);
        chk8(d & 8'h7e, 8'h00);
        chk1(m.hang == 0, 1'b1);
        results();
    end
endmodule
